// ==== logic/io_window_decode.sv ====
// i/o window hit decode for 16-bit i/o addresses
// assumes base and limit nibbles come straight from registers
`timescale 1ns/10ps
module io_window_decode
  import io_window_pkg::*;
(
  input wire logic [3:0] base_nib,   // window base, address bits 15:12
  input wire logic [3:0] limit_nib,  // window limit, address bits 15:12
  input wire logic [15:0] addr,      // i/o address from the hub side
  output logic hit                   // address lies inside the window
);
  logic [15:0] lo_addr; // first byte of the window
  logic [15:0] hi_addr; // last byte of the window

  // build the full window bounds and compare inclusively
  always_comb
  begin
    lo_addr = {base_nib, IO_BASE_LOW_FILL};
    hi_addr = {limit_nib, IO_LIMIT_LOW_FILL};
    // an inverted window never matches since no address meets both ends
    hit = (addr >= lo_addr) && (addr <= hi_addr);
  end
endmodule : io_window_decode

// ==== logic/io_window_pkg.sv ====
// constants for the i/o forwarding window and secondary status registers
// assumes a byte-addressed configuration port with one dword per access
//
// How it works
// - forward i/o whose bits 15:12 fall inside window
// - base low twelve address bits read as zero
// - limit low twelve address bits read as ones
// - addressing capability nibbles read zero, ignore writes
// - status bits clear on written one only
// - bit 15 set on any secondary parity error
// - bit 14 set on secondary system error
// - bit 13 set on forwarded cycle master abort
// - bit 12 set on forwarded cycle target abort
// - completion target abort also signals primary, hub
// - bit 11 never set by this bridge
// - bits 10:9 read-only medium devsel timing
// - devsel timing field reads 01, medium timing
package io_window_pkg;
  // configuration offsets (byte addresses)
  localparam logic [7:0] IO_WINDOW_BASE_OFS = 8'h1c;
  localparam logic [7:0] IO_WINDOW_LIMIT_OFS = 8'h1d;
  localparam logic [7:0] SECONDARY_SIDE_STATUS_OFS = 8'h1e;
  // dword that holds all three registers
  localparam logic [7:0] IO_STATUS_DWORD_OFS = 8'h1c;
  // reset values
  localparam logic [3:0] IO_WINDOW_BASE_RST = 4'h0;
  localparam logic [3:0] IO_WINDOW_LIMIT_RST = 4'h0;
  localparam logic [15:0] SECONDARY_SIDE_STATUS_RST = 16'h02a0;
  // fixed fields
  localparam logic [3:0] IO_ADDR_CAP_16BIT = 4'h0;
  localparam logic [11:0] IO_BASE_LOW_FILL = 12'h000;
  localparam logic [11:0] IO_LIMIT_LOW_FILL = 12'hfff;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  // status bit positions
  localparam int STS_PARITY_BIT = 15;
  localparam int STS_SERR_BIT = 14;
  localparam int STS_MABORT_BIT = 13;
  localparam int STS_TABORT_RCV_BIT = 12;
  localparam int STS_TABORT_SIG_BIT = 11;
  localparam int STS_DEVSEL_LSB = 9;
  localparam int STS_DATA_PERR_BIT = 8;
  localparam int STS_66MHZ_BIT = 5;

  // sticky flag update: a set in the same cycle as a clear wins
  function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
    sticky_next = set | (cur & ~clr);
  endfunction : sticky_next
endpackage : io_window_pkg

// ==== logic/io_window_secondary_status.sv ====
// i/o forwarding window and secondary status configuration registers
// assumes a single-cycle configuration port (byte address of the dword, byte enables)
// and one-cycle event pulses from the secondary bus master logic
`timescale 1ns/10ps
module io_window_secondary_status
  import io_window_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_ack,
  input wire logic io_req_valid,
  input wire logic [15:0] io_req_addr,
  output logic io_fwd_valid,
  output logic io_fwd_hit,
  input wire logic sec_parity_err,
  input wire logic sec_serr_seen,
  input wire logic fwd_master_abort,
  input wire logic fwd_target_abort,
  input wire logic fwd_cmpl_required,
  input wire logic initiator_data_perr,
  input wire logic parity_resp_en,
  output logic target_abort_signaled,
  output logic hub_cmpl_target_abort
);
  // register state
  logic [3:0] base_q; // io_window_base bits 7:4
  logic [3:0] base_d;
  logic [3:0] limit_q; // io_window_limit bits 7:4
  logic [3:0] limit_d;
  logic perr_q; // secondary_parity_error_seen
  logic perr_d;
  logic serr_q; // secondary_system_error_seen
  logic serr_d;
  logic mabort_q; // master_abort_received
  logic mabort_d;
  logic tabort_q; // target_abort_received
  logic tabort_d;
  logic dperr_q; // initiator data parity detected
  logic dperr_d;
  // bus answer state
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rd_ack_q;
  logic rd_ack_d;
  // forwarding decision and hub-side answers
  logic fwd_valid_q;
  logic fwd_valid_d;
  logic fwd_hit_q;
  logic fwd_hit_d;
  logic sta_q;
  logic sta_d;
  logic hub_ta_q;
  logic hub_ta_d;
  // decode and assembled views
  logic sel; // access hits the window/status dword
  logic win_hit; // combinational window compare
  logic [15:0] status_view; // status as software reads it
  logic [7:0] base_view;
  logic [7:0] limit_view;
  logic [7:0] clr_hi; // write-one-to-clear mask for status bits 15:8

  // window compare lives in its own leaf
  io_window_decode u_decode (
    .base_nib (base_q),
    .limit_nib (limit_q),
    .addr (io_req_addr),
    .hit (win_hit)
  );

  // address decode of the configuration port
  always_comb
  begin
    if (cfg_addr == IO_STATUS_DWORD_OFS)
    begin
      sel = 1'b1;
    end
    else
    begin
      sel = 1'b0;
    end
  end

  // software-visible images of the three registers
  always_comb
  begin
    base_view = {base_q, IO_ADDR_CAP_16BIT};
    limit_view = {limit_q, IO_ADDR_CAP_16BIT};
    status_view = SECONDARY_SIDE_STATUS_RST; // fixed bits: 66 MHz, bit 7, devsel
    status_view[STS_DEVSEL_LSB +: 2] = DEVSEL_MEDIUM;
    status_view[STS_TABORT_SIG_BIT] = 1'b0;
    status_view[STS_PARITY_BIT] = perr_q;
    status_view[STS_SERR_BIT] = serr_q;
    status_view[STS_MABORT_BIT] = mabort_q;
    status_view[STS_TABORT_RCV_BIT] = tabort_q;
    status_view[STS_DATA_PERR_BIT] = dperr_q;
  end

  // next values for the writable window fields
  always_comb
  begin
    base_d = base_q;
    limit_d = limit_q;
    if (cfg_wr && sel)
    begin
      // only the upper nibble of each byte takes data
      if (cfg_be[0])
      begin
        base_d = cfg_wdata[7:4];
      end
      if (cfg_be[1])
      begin
        limit_d = cfg_wdata[15:12];
      end
    end
  end

  // next values for the sticky status flags
  always_comb
  begin
    // only the top status byte holds clearable bits
    if (cfg_wr && sel && cfg_be[3])
    begin
      clr_hi = cfg_wdata[31:24];
    end
    else
    begin
      clr_hi = 8'h00;
    end
    // parity error is recorded regardless of the response enable
    perr_d = sticky_next(perr_q, sec_parity_err, clr_hi[STS_PARITY_BIT - 8]);
    serr_d = sticky_next(serr_q, sec_serr_seen, clr_hi[STS_SERR_BIT - 8]);
    mabort_d = sticky_next(mabort_q, fwd_master_abort, clr_hi[STS_MABORT_BIT - 8]);
    tabort_d = sticky_next(tabort_q, fwd_target_abort, clr_hi[STS_TABORT_RCV_BIT - 8]);
    dperr_d = sticky_next(dperr_q, initiator_data_perr & parity_resp_en, clr_hi[STS_DATA_PERR_BIT - 8]);
  end

  // next values for read answer, forwarding decision and abort reporting
  always_comb
  begin
    rd_ack_d = cfg_rd;
    rdata_d = 32'h0000_0000;
    if (cfg_rd && sel)
    begin
      rdata_d = {status_view, limit_view, base_view};
    end
    // unmapped reads answer with zero
    fwd_valid_d = io_req_valid;
    fwd_hit_d = io_req_valid & win_hit;
    // completion-required target abort goes back to the hub and primary
    sta_d = fwd_target_abort & fwd_cmpl_required;
    hub_ta_d = fwd_target_abort & fwd_cmpl_required;
  end

  // register all state; clock enable freezes everything
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      base_q <= IO_WINDOW_BASE_RST;
      limit_q <= IO_WINDOW_LIMIT_RST;
      perr_q <= SECONDARY_SIDE_STATUS_RST[STS_PARITY_BIT];
      serr_q <= SECONDARY_SIDE_STATUS_RST[STS_SERR_BIT];
      mabort_q <= SECONDARY_SIDE_STATUS_RST[STS_MABORT_BIT];
      tabort_q <= SECONDARY_SIDE_STATUS_RST[STS_TABORT_RCV_BIT];
      dperr_q <= SECONDARY_SIDE_STATUS_RST[STS_DATA_PERR_BIT];
      rdata_q <= 32'h0000_0000;
      rd_ack_q <= 1'b0;
      fwd_valid_q <= 1'b0;
      fwd_hit_q <= 1'b0;
      sta_q <= 1'b0;
      hub_ta_q <= 1'b0;
    end
    else if (clk_en)
    begin
      base_q <= base_d;
      limit_q <= limit_d;
      perr_q <= perr_d;
      serr_q <= serr_d;
      mabort_q <= mabort_d;
      tabort_q <= tabort_d;
      dperr_q <= dperr_d;
      rdata_q <= rdata_d;
      rd_ack_q <= rd_ack_d;
      fwd_valid_q <= fwd_valid_d;
      fwd_hit_q <= fwd_hit_d;
      sta_q <= sta_d;
      hub_ta_q <= hub_ta_d;
    end
  end

  // outputs straight from flip-flops
  assign cfg_rdata = rdata_q;
  assign cfg_rd_ack = rd_ack_q;
  assign io_fwd_valid = fwd_valid_q;
  assign io_fwd_hit = fwd_hit_q;
  assign target_abort_signaled = sta_q;
  assign hub_cmpl_target_abort = hub_ta_q;
endmodule : io_window_secondary_status

// ==== test/io_window_checker.sv ====
// checker: port assertions for the i/o window and status block
// assumes it is bound onto io_window_secondary_status
`timescale 1ns/10ps
module io_window_checker (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rd_ack,
  input wire logic io_req_valid,
  input wire logic io_fwd_valid,
  input wire logic sec_parity_err,
  input wire logic sec_serr_seen,
  input wire logic fwd_master_abort,
  input wire logic fwd_target_abort,
  input wire logic fwd_cmpl_required,
  input wire logic target_abort_signaled,
  input wire logic hub_cmpl_target_abort
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // read of the mapped dword
  sequence rd_map;
    clk_en && cfg_rd && cfg_addr == 8'h1c;
  endsequence
  // target abort on a cycle that needs a completion
  sequence ta_cmpl;
    clk_en && fwd_target_abort && fwd_cmpl_required;
  endsequence
  a_fwd_valid_next: assert property (clk_en && io_req_valid |=> io_fwd_valid) else $error("fwd late");
  a_cap_nibbles: assert property (cfg_rd_ack |-> cfg_rdata[11:8] == 4'h0 && cfg_rdata[3:0] == 4'h0)
    else $error("cap nibble");
  a_fixed_status: assert property (rd_map |=> cfg_rdata[27:25] == 3'h1 && cfg_rdata[21])
    else $error("fixed bits");
  a_parity_kept: assert property (clk_en && sec_parity_err ##1 !cfg_wr ##1 rd_map |=> cfg_rdata[31])
    else $error("parity bit");
  a_serr_kept: assert property (clk_en && sec_serr_seen ##1 !cfg_wr ##1 rd_map |=> cfg_rdata[30])
    else $error("serr bit");
  a_mabort_kept: assert property (clk_en && fwd_master_abort ##1 !cfg_wr ##1 rd_map |=> cfg_rdata[29])
    else $error("mabort bit");
  a_ta_pulses: assert property (ta_cmpl |=> target_abort_signaled && hub_cmpl_target_abort)
    else $error("ta pulse");
  a_ta_cause: assert property ($rose(target_abort_signaled) |-> $past(fwd_target_abort && fwd_cmpl_required))
    else $error("ta cause");
endmodule : io_window_checker
bind io_window_secondary_status io_window_checker i_chk (.*);

// ==== test/io_window_secondary_status_tb.sv ====
// bench for the i/o window and secondary status registers
// assumes sec_bus_agent drives the bus events
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module io_window_secondary_status_tb;
  import io_window_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, io_req_valid = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
  logic [15:0] io_req_addr = 16'h0;
  logic cfg_rd_ack, io_fwd_valid, io_fwd_hit, sec_parity_err, sec_serr_seen, fwd_master_abort;
  logic fwd_target_abort, fwd_cmpl_required, target_abort_signaled, hub_cmpl_target_abort;
  logic initiator_data_perr = 1'b0; // initiator-side data parity pulse (status bit 8)
  logic parity_resp_en = 1'b0; // parity response enable level from bridge control
  int n_errors = 0, comparisons = 0;
  io_window_secondary_status i_dut (.*);
  sec_bus_agent i_agent (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  // config write, taken at the second edge
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge sys_clk) {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, be, d};
    @(posedge sys_clk) cfg_wr <= 1'b0;
  endtask : cfg_write
  // config read, answer checked one cycle later
  task automatic cfg_read(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk) {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge sys_clk) cfg_rd <= 1'b0;
    @(negedge sys_clk) `CHK({cfg_rd_ack, cfg_rdata}, {1'b1, e})
  endtask : cfg_read
  // one i/o request and its forward decision
  task automatic io_probe(input logic [15:0] a, input logic e);
    @(posedge sys_clk) {io_req_valid, io_req_addr} <= {1'b1, a};
    @(posedge sys_clk) io_req_valid <= 1'b0;
    @(negedge sys_clk) `CHK({io_fwd_valid, io_fwd_hit}, {1'b1, e})
  endtask : io_probe
  // reset values, read-only fields, unmapped place
  task automatic t_regs;
    cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST, 16'h0000});
    cfg_write(8'h1c, 4'hf, 32'hffff_ffff);
    cfg_read(8'h1c, 32'h02a0_f0f0);
    cfg_write(8'h20, 4'hf, 32'h0000_1010);
    cfg_read(8'h20, 32'h0);
  endtask : t_regs
  // window edges for base 2, limit 4, then base above limit
  task automatic t_window;
    cfg_write(8'h1c, 4'h3, 32'h0000_4020);
    io_probe(16'h1fff, 1'b0);
    io_probe(16'h2000, 1'b1);
    io_probe(16'h3abc, 1'b1);
    io_probe(16'h4fff, 1'b1);
    io_probe(16'h5000, 1'b0);
    cfg_write(8'h1c, 4'h1, 32'h0000_0050);
    io_probe(16'h4800, 1'b0);
    io_probe(16'h5000, 1'b0);
  endtask : t_window
  // each event sets its bit; zero keeps it, one clears it
  task automatic t_events;
    logic [15:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = 16'h8000 >> i;
      i_agent.fire(i == 3 ? 5'h18 : 5'h01 << i);
      if (i == 3)
        @(negedge sys_clk) `CHK({target_abort_signaled, hub_cmpl_target_abort}, 2'b11)
      cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST | m, 16'h4050});
      cfg_write(8'h1c, 4'hc, 32'h0);
      cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST | m, 16'h4050});
      cfg_write(8'h1c, 4'hc, {m, 16'h0000});
      cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST, 16'h4050});
    end
  endtask : t_events
  // bus parity sets bit 15 with the enable high too; bit 8 needs the enable
  task automatic t_perr_en;
    @(posedge sys_clk) {initiator_data_perr, parity_resp_en} <= 2'b10;
    @(posedge sys_clk) {initiator_data_perr, parity_resp_en} <= 2'b01;
    cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST, 16'h4050});
    @(posedge sys_clk) initiator_data_perr <= 1'b1;
    @(posedge sys_clk) initiator_data_perr <= 1'b0;
    i_agent.fire(5'h01);
    cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST | 16'h8100, 16'h4050});
    cfg_write(8'h1c, 4'h8, 32'h8100_0000);
    cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST, 16'h4050});
    @(posedge sys_clk) parity_resp_en <= 1'b0;
  endtask : t_perr_en
  // clock enable low: write, event and abort pulses are all ignored
  task automatic t_freeze;
    @(posedge sys_clk) clk_en <= 1'b0;
    cfg_write(8'h1c, 4'hf, 32'hffff_f0f0);
    i_agent.fire(5'h18);
    @(negedge sys_clk) `CHK({target_abort_signaled, hub_cmpl_target_abort}, 2'b00)
    @(posedge sys_clk) clk_en <= 1'b1;
    cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST, 16'h4050});
  endtask : t_freeze
  // abort with no completion owed; an event and its clear in one cycle keep the bit
  task automatic t_abort_nocmpl;
    i_agent.fire(5'h08);
    @(negedge sys_clk) `CHK({target_abort_signaled, hub_cmpl_target_abort}, 2'b00)
    fork
      i_agent.fire(5'h04);
      cfg_write(8'h1c, 4'h8, 32'h3000_0000);
    join
    cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST | 16'h2000, 16'h4050});
    cfg_write(8'h1c, 4'h8, 32'h2000_0000);
    cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST, 16'h4050});
  endtask : t_abort_nocmpl
  // reset in mid-run brings back the reset window and status
  task automatic t_reset;
    i_agent.fire(5'h02);
    @(posedge sys_clk) arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    cfg_read(8'h1c, {SECONDARY_SIDE_STATUS_RST, 16'h0000});
    io_probe(16'h0abc, 1'b1);
    io_probe(16'h1000, 1'b0);
  endtask : t_reset
  task automatic final_report;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_window();
    t_events();
    t_perr_en();
    t_freeze();
    t_abort_nocmpl();
    t_reset();
    final_report();
  end
  // watchdog for a hung run
  initial
  begin
    #50us;
    n_errors++;
    final_report();
  end
endmodule : io_window_secondary_status_tb

// ==== test/sec_bus_agent.sv ====
// secondary bus agent model: raises the bus event pulses
// assumes fire() is called from the bench
`timescale 1ns/10ps
module sec_bus_agent (
  input wire logic sys_clk,
  output logic sec_parity_err,
  output logic sec_serr_seen,
  output logic fwd_master_abort,
  output logic fwd_target_abort,
  output logic fwd_cmpl_required
);
  logic [4:0] ev_q = 5'h00; // cmpl, tabort, mabort, serr, parity
  assign {fwd_cmpl_required, fwd_target_abort, fwd_master_abort, sec_serr_seen, sec_parity_err} = ev_q;
  // one-cycle pulse launched and dropped on rising edges
  task automatic fire(input logic [4:0] ev);
    @(posedge sys_clk) ev_q <= ev;
    @(posedge sys_clk) ev_q <= 5'h00;
  endtask : fire
endmodule : sec_bus_agent
